// ---- rtl/tmps_timer.sv ----
// 8-bit timer with shared prescaler behind an APB slave
// assumes pins are asynchronous; watchdog consumes wdt_tick_out
`timescale 1ns/1ns
`include "tmps_defs.svh"
// Overview of operation
// - source bit selects pin or quarter clock; touch select forces the oscillator
// - edge bit one counts falling pin edges
// - prescaler goes to watchdog or timer only
// - rate field sets 1:2..1:256 or 1:1..1:128
// - irq edge bit one means rising edge
// - option bits all writable, reset to one
// - touch control: select bit0, status bit1
module tmps_timer
  import tmps_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_clock_pin_in,
  input wire logic touch_sense_osc_in,
  input wire logic ext_irq_pin_in,
  output logic irq_out,
  output logic wdt_tick_out,
  output logic touch_enable_out,
  output logic [1:0] touch_range_out,
  output logic pullup_disable_n_out
);
  tmps_tick_if tk ();
  tmps_byte_t option_r, option_nxt;
  tmps_byte_t touch_r, touch_nxt;
  tmps_byte_t irqc_r, irqc_nxt;
  tmps_byte_t count_r, count_nxt;
  logic [1:0] quarter_r, quarter_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  tmps_apb_state_t st_r, st_nxt;
  logic pin_lvl, pin_rise, pin_fall;
  logic osc_lvl, osc_rise, osc_fall;
  logic irq_lvl, irq_rise, irq_fall;
  logic ext_tick, insn_tick, wrap, ext_evt;
  logic wr_en, rd_en, hit;
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == `TMPS_OFF_OPTION) || (a == `TMPS_OFF_TOUCH) ||
              (a == `TMPS_OFF_IRQ) || (a == `TMPS_OFF_COUNT);
  endfunction
  tmps_edge_sync u_pin (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .async_in(timer_clock_pin_in),
    .level_out(pin_lvl), .rise_out(pin_rise), .fall_out(pin_fall));
  tmps_edge_sync u_osc (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .async_in(touch_sense_osc_in),
    .level_out(osc_lvl), .rise_out(osc_rise), .fall_out(osc_fall));
  tmps_edge_sync u_irq (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .async_in(ext_irq_pin_in),
    .level_out(irq_lvl), .rise_out(irq_rise), .fall_out(irq_fall));
  tmps_prescaler u_psc (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .tk(tk));
  // APB: setup then a single access cycle with pready high
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      TMPS_IDLE: if (psel && !penable) st_nxt = TMPS_ACCESS;
      TMPS_ACCESS: st_nxt = (psel && !penable) ? TMPS_ACCESS : TMPS_IDLE;
    endcase
  end
  assign hit = reg_hit(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_en = psel & ~penable & ~pwrite;
  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_en) begin
      unique case (paddr)
        `TMPS_OFF_OPTION: prdata_nxt = {24'h000000, option_r};
        `TMPS_OFF_TOUCH: prdata_nxt = {24'h000000, touch_r[7], 3'h0, touch_r[3:2],
                                       osc_lvl, touch_r[0]};
        `TMPS_OFF_IRQ: prdata_nxt = {24'h000000, irqc_r};
        `TMPS_OFF_COUNT: prdata_nxt = {24'h000000, count_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end
  // tick sources
  always_comb begin
    quarter_nxt = quarter_r + 2'h1;
    insn_tick = (quarter_r == `TMPS_INSN_DIV);
    if (touch_r[`TMPS_BIT_TOUCH_TSEL]) begin
      ext_tick = option_r[`TMPS_BIT_EDGE_SEL] ? osc_fall : osc_rise;
    end else begin
      ext_tick = option_r[`TMPS_BIT_EDGE_SEL] ? pin_fall : pin_rise;
    end
    ext_evt = option_r[`TMPS_BIT_IRQ_EDGE] ? irq_rise : irq_fall;
  end
  // touch select routes the oscillator in; otherwise source bit picks pin or quarter clock
  assign tk.src_tick = touch_r[`TMPS_BIT_TOUCH_TSEL] ? ext_tick :
    (option_r[`TMPS_BIT_SRC_SEL] ? ext_tick : insn_tick);
  assign tk.to_wdt = option_r[`TMPS_BIT_PSC_ASSIGN];
  assign tk.rate = option_r[2:0];
  assign tk.clear = wr_en && (paddr == `TMPS_OFF_COUNT);
  assign wrap = (tk.to_wdt ? tk.src_tick : tk.timer_tick) && (count_r == 8'hFF);
  always_comb begin
    option_nxt = option_r;
    touch_nxt = touch_r;
    irqc_nxt = irqc_r;
    count_nxt = count_r;
    if (tk.to_wdt ? tk.src_tick : tk.timer_tick) count_nxt = count_r + 8'h01;
    if (wr_en) begin
      unique case (paddr)
        `TMPS_OFF_OPTION: option_nxt = pwdata[7:0];
        `TMPS_OFF_TOUCH: touch_nxt = pwdata[7:0] & `TMPS_TOUCH_WMASK;
        `TMPS_OFF_IRQ: irqc_nxt = pwdata[7:0];
        `TMPS_OFF_COUNT: count_nxt = pwdata[7:0];
        default: ;
      endcase
    end
    // hardware set wins over a software clear
    if (wrap) irqc_nxt[`TMPS_BIT_WRAP_FLAG] = 1'b1;
    if (ext_evt) irqc_nxt[`TMPS_BIT_EXT_FLAG] = 1'b1;
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      option_r <= `TMPS_OPTION_RST;
      touch_r <= `TMPS_TOUCH_RST;
      irqc_r <= `TMPS_IRQ_RST;
      count_r <= `TMPS_COUNT_RST;
      quarter_r <= 2'h0;
      prdata_r <= 32'h00000000;
      st_r <= TMPS_IDLE;
    end else begin
      option_r <= option_nxt;
      touch_r <= touch_nxt;
      irqc_r <= irqc_nxt;
      count_r <= count_nxt;
      quarter_r <= quarter_nxt;
      prdata_r <= prdata_nxt;
      st_r <= st_nxt;
    end
  end
  assign prdata = prdata_r;
  assign irq_out = irqc_r[`TMPS_BIT_GIE] &
    ((irqc_r[`TMPS_BIT_WRAP_IE] & irqc_r[`TMPS_BIT_WRAP_FLAG]) |
     (irqc_r[`TMPS_BIT_EXT_IE] & irqc_r[`TMPS_BIT_EXT_FLAG]));
  assign wdt_tick_out = tk.wdt_tick;
  assign touch_enable_out = touch_r[`TMPS_BIT_TOUCH_ON];
  assign touch_range_out = touch_r[3:2];
  assign pullup_disable_n_out = ~option_r[`TMPS_BIT_PULLUP_OFF];

  sequence s_wrap_seen;
    wrap && !wr_en;
  endsequence
  a_wrap_flag: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    s_wrap_seen |=> irqc_r[`TMPS_BIT_WRAP_FLAG] && count_r == 8'h00)
    else $error("wrap did not set flag or zero count");
  a_insn_quarter: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!option_r[`TMPS_BIT_SRC_SEL] && !touch_r[`TMPS_BIT_TOUCH_TSEL] && tk.src_tick) |=>
    !tk.src_tick [*3])
    else $error("internal tick faster than quarter clock");
  a_edge_fall: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (option_r[`TMPS_BIT_SRC_SEL] && option_r[`TMPS_BIT_EDGE_SEL] &&
     !touch_r[`TMPS_BIT_TOUCH_TSEL] && tk.src_tick) |-> $fell(pin_lvl))
    else $error("counted on wrong pin edge");
  a_ext_irq_edge: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (ext_evt && option_r[`TMPS_BIT_IRQ_EDGE]) |-> irq_rise ##1
    irqc_r[`TMPS_BIT_EXT_FLAG])
    else $error("external irq edge wrong");
  a_option_rst: assert property (@(posedge ref_clk_in)
    $past(rst_in) |-> option_r == `TMPS_OPTION_RST)
    else $error("option reset value wrong");
  a_touch_rd: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (rd_en && paddr == `TMPS_OFF_TOUCH) |=> prdata[6:4] == 3'h0 &&
    prdata[0] == touch_r[0])
    else $error("touch control readback wrong");
  a_irq_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    irq_out |-> irqc_r[`TMPS_BIT_GIE])
    else $error("irq without global enable");
endmodule // tmps_timer

// ---- inc/tmps_defs.svh ----
// register offsets, field positions, reset values and timing for the timer block
// included by the timer, the prescaler and the bench; definitions only
`ifndef TMPS_DEFS_SVH
`define TMPS_DEFS_SVH
`define TMPS_OFF_OPTION 12'h000
`define TMPS_OFF_TOUCH 12'h004
`define TMPS_OFF_IRQ 12'h008
`define TMPS_OFF_COUNT 12'h00C
`define TMPS_OPTION_RST 8'hFF
`define TMPS_TOUCH_RST 8'h00
`define TMPS_IRQ_RST 8'h00
`define TMPS_COUNT_RST 8'h00
`define TMPS_BIT_PULLUP_OFF 7
`define TMPS_BIT_IRQ_EDGE 6
`define TMPS_BIT_SRC_SEL 5
`define TMPS_BIT_EDGE_SEL 4
`define TMPS_BIT_PSC_ASSIGN 3
`define TMPS_BIT_TOUCH_ON 7
`define TMPS_BIT_TOUCH_STAT 1
`define TMPS_BIT_TOUCH_TSEL 0
`define TMPS_BIT_GIE 7
`define TMPS_BIT_WRAP_IE 5
`define TMPS_BIT_EXT_IE 4
`define TMPS_BIT_WRAP_FLAG 2
`define TMPS_BIT_EXT_FLAG 1
`define TMPS_INSN_DIV 2'h3
`define TMPS_TOUCH_WMASK 8'h8D
`endif

// ---- inc/tmps_pkg.sv ----
// types shared by the timer block
// assumes tmps_defs.svh sits in the include path
package tmps_pkg;
  typedef enum logic [1:0] {
    TMPS_IDLE,
    TMPS_ACCESS
  } tmps_apb_state_t;
  typedef logic [7:0] tmps_byte_t;
endpackage

// ---- inc/tmps_tick_if.sv ----
// carries count ticks from the prescaler to the core
// assumes one clock shared by all ends
`timescale 1ns/1ns
interface tmps_tick_if;
  logic src_tick;
  logic timer_tick;
  logic wdt_tick;
  logic clear;
  logic [2:0] rate;
  logic to_wdt;
  modport psc (input src_tick, input clear, input rate, input to_wdt,
               output timer_tick, output wdt_tick);
  modport core (output src_tick, output clear, output rate, output to_wdt,
                input timer_tick, input wdt_tick);
endinterface

// ---- rtl/tmps_edge_sync.sv ----
// two-flop synchroniser with rising and falling edge pulses
// assumes the input is asynchronous to ref_clk_in
`timescale 1ns/1ns
module tmps_edge_sync (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_r, sync_r, prev_r;
  logic meta_nxt, sync_nxt, prev_nxt;
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end
  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;
  assign fall_out = ~sync_r & prev_r;
endmodule // tmps_edge_sync

// ---- rtl/tmps_prescaler.sv ----
// shared 8-bit prescaler, routed to the timer or the watchdog
// assumes ticks are one-cycle pulses on the common clock
`timescale 1ns/1ns
`include "tmps_defs.svh"
module tmps_prescaler (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  tmps_tick_if.psc tk
);
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] inc;
  logic tap;
  // true when the low n+1 bits are all ones, so the next tick carries out
  function automatic logic low_full(input logic [7:0] c, input logic [2:0] n);
    logic [8:0] m;
    m = (9'h002 << n) - 9'h001;
    low_full = &(c | ~m[7:0]);
  endfunction
  always_comb begin
    inc = cnt_r + 8'h01;
    tap = 1'b0;
    if (tk.to_wdt) begin
      // watchdog 1:1 at code 0
      tap = (tk.rate == 3'h0) ? 1'b1 : low_full(cnt_r, tk.rate - 3'h1);
    end else begin
      tap = low_full(cnt_r, tk.rate);
    end
    cnt_nxt = tk.clear ? 8'h00 : (tk.src_tick ? inc : cnt_r);
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // one output only, per assignment bit
  assign tk.timer_tick = tk.src_tick & ~tk.to_wdt & ~tk.clear & tap;
  assign tk.wdt_tick = tk.src_tick & tk.to_wdt & ~tk.clear & tap;
  a_wdt_div1: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (tk.to_wdt && tk.rate == 3'h0 && tk.src_tick && !tk.clear) |-> tk.wdt_tick)
    else $error("watchdog 1:1 tick missing");
  a_psc_excl: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !(tk.timer_tick && tk.wdt_tick))
    else $error("prescaler serves both");
  a_div2_gap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (tk.timer_tick && !tk.to_wdt && tk.rate == 3'h0 && $stable(tk.rate)) |->
    ##1 (!tk.timer_tick))
    else $error("1:2 tick back to back");
endmodule // tmps_prescaler

// ---- bench/tmps_pin_model.sv ----
// far-side pin model: timer clock pin, touch oscillator and interrupt pin
// assumes the bench clock; lines idle low and each level from pulses lasts three clocks
`timescale 1ns/1ns
module tmps_pin_model (
  input wire logic ref_clk_in,
  output logic timer_clock_pin_out,
  output logic touch_osc_out,
  output logic ext_irq_out
);
  initial begin
    timer_clock_pin_out = 1'b0;
    touch_osc_out = 1'b0;
    ext_irq_out = 1'b0;
  end
  // which 0 toggles the timer clock pin, 1 the touch oscillator; ends low
  task automatic pulses(input int which, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge ref_clk_in);
      if (which == 0) timer_clock_pin_out <= ~timer_clock_pin_out;
      else touch_osc_out <= ~touch_osc_out;
      repeat (2) @(posedge ref_clk_in);
    end
  endtask
  task automatic irq_level(input logic v);
    @(posedge ref_clk_in);
    ext_irq_out <= v;
  endtask
endmodule // tmps_pin_model

// ---- bench/tb.sv ----
// self-checking bench for the timer block: apb tasks and pin stimulus
// assumes zero-wait apb slave and pins synced inside the design
`timescale 1ns/1ns
`include "tmps_defs.svh"
module tb;
  logic ref_clk_in, rst_in, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pin, osc, irq_pin, irq_out, wdt_tick_out, touch_enable_out, pullup_disable_n_out;
  logic [1:0] touch_range_out;
  int err_count = 0, checks = 0, cycles = 0, wdt_n = 0;
  tmps_timer tmps_timer_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_clock_pin_in(pin), .touch_sense_osc_in(osc),
    .ext_irq_pin_in(irq_pin), .irq_out(irq_out), .wdt_tick_out(wdt_tick_out),
    .touch_enable_out(touch_enable_out), .touch_range_out(touch_range_out),
    .pullup_disable_n_out(pullup_disable_n_out));
  tmps_pin_model tmps_pin_model_i (.ref_clk_in(ref_clk_in), .timer_clock_pin_out(pin),
    .touch_osc_out(osc), .ext_irq_out(irq_pin));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (wdt_tick_out === 1'b1) wdt_n <= wdt_n + 1;
    if (cycles == 30000) begin
      err_count = err_count + 1;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h000000, d}, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    check(q, exp);
  endtask
  task automatic ext_count(input logic [7:0] opt, input int n, input logic [31:0] exp);
    wr(`TMPS_OFF_OPTION, opt);
    wr(`TMPS_OFF_COUNT, 8'h00);
    tmps_pin_model_i.pulses(0, n);
    repeat (6) @(posedge ref_clk_in);
    rd(`TMPS_OFF_COUNT, exp);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    logic [31:0] q;
    logic e;
    rst_in = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    rd(`TMPS_OFF_OPTION, 32'h000000FF);
    check(pullup_disable_n_out, 1'b0);
    rd(`TMPS_OFF_TOUCH, 32'h00000000);
    rd(`TMPS_OFF_IRQ, 32'h00000000);
    rd(`TMPS_OFF_COUNT, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000, q, e);
    check(q, 32'h00000000);
    check(e, 1'b1);
    wr(`TMPS_OFF_OPTION, 8'h5A);
    rd(`TMPS_OFF_OPTION, 32'h0000005A);
    $display("test reset and registers done");
    // internal quarter-clock source, prescaler on the watchdog
    wr(`TMPS_OFF_OPTION, 8'h08);
    wr(`TMPS_OFF_COUNT, 8'h00);
    repeat (40) @(posedge ref_clk_in);
    apb(1'b0, `TMPS_OFF_COUNT, 32'h00000000, q, e);
    check({31'h0, q >= 32'd10 && q <= 32'd12}, 32'h1);
    ext_count(8'h28, 5, 32'h00000005);
    ext_count(8'h38, 3, 32'h00000003);
    $display("test count sources done");
    for (int r = 0; r < 8; r++) begin
      wdt_n = 0;
      ext_count(8'h20 | r[7:0], (2 << r) - 1, 32'h00000000);
      tmps_pin_model_i.pulses(0, 1);
      repeat (6) @(posedge ref_clk_in);
      rd(`TMPS_OFF_COUNT, 32'h00000001);
      check(wdt_n, 32'h0);
    end
    $display("test prescaler rates done");
    wr(`TMPS_OFF_OPTION, 8'h28);
    wr(`TMPS_OFF_IRQ, 8'hA0);
    wr(`TMPS_OFF_COUNT, 8'hFE);
    tmps_pin_model_i.pulses(0, 2);
    repeat (6) @(posedge ref_clk_in);
    rd(`TMPS_OFF_COUNT, 32'h00000000);
    rd(`TMPS_OFF_IRQ, 32'h000000A4);
    check(irq_out, 1'b1);
    wr(`TMPS_OFF_IRQ, 8'hA0);
    check(irq_out, 1'b0);
    $display("test wrap done");
    wr(`TMPS_OFF_OPTION, 8'h68);
    wr(`TMPS_OFF_IRQ, 8'h10);
    tmps_pin_model_i.irq_level(1'b1);
    repeat (6) @(posedge ref_clk_in);
    rd(`TMPS_OFF_IRQ, 32'h00000012);
    wr(`TMPS_OFF_OPTION, 8'h28);
    wr(`TMPS_OFF_IRQ, 8'h10);
    tmps_pin_model_i.irq_level(1'b0);
    repeat (6) @(posedge ref_clk_in);
    rd(`TMPS_OFF_IRQ, 32'h00000012);
    $display("test interrupt edge done");
    wr(`TMPS_OFF_TOUCH, 8'hFF);
    rd(`TMPS_OFF_TOUCH, 32'h0000008D);
    check({touch_enable_out, touch_range_out}, 3'h7);
    wr(`TMPS_OFF_TOUCH, 8'h01);
    wr(`TMPS_OFF_OPTION, 8'h08);
    wr(`TMPS_OFF_COUNT, 8'h00);
    tmps_pin_model_i.pulses(1, 4);
    repeat (6) @(posedge ref_clk_in);
    rd(`TMPS_OFF_COUNT, 32'h00000004);
    $display("test touch source done");
    test_done();
  end
endmodule // tb
